// >>> rtl/mcs_pkg.sv
// Purpose: Constants and types shared by the memory checksum scanner.
// Assumes: Byte-wide register port and a 16-bit program memory read port.
// Notes: Region ends arrive as inputs already decoded from configuration.
package mcs_pkg;
   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [1:0] MCS_OFS_CONTROL = 2'h0;
   localparam logic [1:0] MCS_OFS_MODE_SOURCE = 2'h1;
   localparam logic [1:0] MCS_OFS_RESULT_STATE = 2'h2;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int MCS_BIT_ENABLE = 0;
   localparam int MCS_BIT_FATAL_EN = 1;
   localparam int MCS_BIT_LOCAL_RESET = 7;
   localparam int MCS_BIT_BUSY = 0;
   localparam int MCS_BIT_OK = 1;
   localparam int MCS_POS_REGION = 0;
   localparam int MCS_POS_MODE = 4;
   // ----------------------------------------------------------------
   // Reset values and encodings
   // ----------------------------------------------------------------
   localparam logic [1:0] MCS_REGION_WHOLE = 2'h0;
   localparam logic [1:0] MCS_REGION_BOOT_APP = 2'h1;
   localparam logic [1:0] MCS_REGION_BOOT = 2'h2;
   localparam logic [1:0] MCS_MODE_PRIORITY = 2'h0;
   localparam logic [1:0] MCS_MODE_STARTUP = 2'h1;
   localparam logic [15:0] MCS_CRC_INIT = 16'hffff;
   localparam logic [15:0] MCS_CRC_POLY = 16'h1021;
   localparam logic [15:0] MCS_CRC_PASS = 16'h0000;
   localparam logic [15:0] MCS_REGION_UNIT = 16'h0100;
   localparam logic [7:0] MCS_NMI_VECTOR = 8'h00;
   // ----------------------------------------------------------------
   // Timing counts
   // ----------------------------------------------------------------
   localparam logic [1:0] MCS_START_DELAY = 2'h3;
   localparam logic [1:0] MCS_FETCH_PERIOD = 2'h3;
   // Scanner states.
   typedef enum logic [2:0] {
      MCS_IDLE,
      MCS_DELAY,
      MCS_FETCH,
      MCS_WAIT,
      MCS_CHECK
   } mcs_state_type;
endpackage : mcs_pkg

// >>> rtl/mcs_scanner.sv
// Purpose: Program memory checksum scanner with priority memory access.
// Assumes: One clock, synchronous inputs, last byte address and boot region ends in 256-byte units given.
// Notes: Memory read data is valid the cycle after the read strobe.
//
// Behaviour
// - Debugger access disables scanning
// - Debugger disconnect after touch restarts check
// - Busy stays 1 while debugger holds
// - Debugger busy write 0 abandons check
// - Debugger busy write 1 queues check
// - Busy locks mode/source and interrupt enable
// - Debugger ok clear raises fatal; locks writes
// - Debugger ok write 1 shows ok idle
// - Debugger control writes equal processor writes
// - Scan starts three cycles after enable
// - Startup failure blocks processor; shows settings
// - Scanner owns memory, stalls processor
// - One word each third cycle
// - Failure clears ok, fatal request sticks
// - Interrupt enable sticky, set only idle
// - Local reset strobe restores registers except interrupt enable, fatal request and failure latch
// - Enable stays 1 while busy; rewrite restarts
// - Disable waits for region end
// - Sleep pauses scan, resumes on wake
// - Sleep in delay defers scan start
// - Generator starts at all ones
// - Bytes upward, msb first, CCITT
// - Ok reads 1 at reset, 0 busy
// - Region select encoding
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps
module mcs_scanner (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [1:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_dbg_access,
   input wire logic i_dbg_release,
   input wire logic i_dbg_status_wr,
   input wire logic i_sleep,
   input wire logic i_startup_req,
   input wire logic [1:0] i_startup_region,
   input wire logic [15:0] i_last_memory_byte,
   input wire logic [15:0] i_boot_region_end,
   input wire logic [15:0] i_boot_app_region_end,
   input wire logic [15:0] i_mem_rdata,
   output logic [7:0] o_rdata,
   output logic o_mem_rd,
   output logic [15:0] o_mem_addr,
   output logic o_cpu_stall,
   output logic o_startup_fail,
   output logic o_nmi_req,
   output logic [7:0] o_nmi_vector
);
   import mcs_pkg::*;

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   // Feeds one byte through the generator, most significant bit first.
   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c;
      for (int k = 7; k >= 0; k--) begin
         if (r[15] ^ b[k]) begin
            r = {r[14:0], 1'b0} ^ MCS_CRC_POLY;
         end else begin
            r = {r[14:0], 1'b0};
         end
      end
      return r;
   endfunction : crc_byte

   // Gives the byte address one past the end of the chosen region.
   function automatic logic [16:0] region_limit(input logic [1:0] sel, input logic [15:0] whole,
                                                input logic [15:0] boot, input logic [15:0] bapp);
      logic [16:0] v;
      v = {1'b0, whole} + 17'h00001;
      unique case (sel)
         MCS_REGION_BOOT_APP: v = {1'b0, bapp[7:0], 8'h00};
         MCS_REGION_BOOT: v = {1'b0, boot[7:0], 8'h00};
         default: v = {1'b0, whole} + 17'h00001;
      endcase
      return v;
   endfunction : region_limit

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      mcs_state_type st;       // Sequencer state.
      logic enable;            // Enable bit.
      logic fatal_en;          // Fatal interrupt enable.
      logic [1:0] mode;        // Access mode field.
      logic [1:0] region;      // Region select field.
      logic busy;              // Busy status.
      logic ok;                // Ok status.
      logic held;              // Debugger holds the scanner off.
      logic local_rst;         // Local reset pending for next cycle.
      logic nmi;               // Sticky fatal request.
      logic startup;           // Current check is the startup check.
      logic disable_pend;      // Enable cleared during a check.
      logic [1:0] cnt;         // Delay and fetch pacing counter.
      logic [16:0] addr;       // Next byte address.
      logic [16:0] limit;      // Region end, exclusive.
      logic [15:0] crc;        // Generator state.
      logic [7:0] rdata;       // Read data register.
      logic mem_rd;            // Memory read strobe.
      logic stall;             // Processor stall.
      logic fail;              // Startup failure latch.
   } mcs_regs_type;

   mcs_regs_type s_r;
   mcs_regs_type s_nxt;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   // Decodes register traffic and advances the sequencer.
   always_comb begin
      logic wr_ctl;
      logic wr_ms;
      logic wr_st;
      logic start;
      wr_ctl = 1'b0;
      wr_ms = 1'b0;
      wr_st = 1'b0;
      start = 1'b0;
      s_nxt = s_r;
      s_nxt.mem_rd = 1'b0;
      // shared write path
      // Writes from debugger and processor share one path; all lock after a fatal request.
      // writes locked after fatal
      if (i_wr && !s_r.nmi) begin
         wr_ctl = (i_addr == MCS_OFS_CONTROL);
         wr_ms = (i_addr == MCS_OFS_MODE_SOURCE);
         wr_st = (i_addr == MCS_OFS_RESULT_STATE) && i_dbg_status_wr;
      end
      // Read data is presented the cycle after the read strobe.
      if (i_rd) begin
         unique case (i_addr)
            MCS_OFS_CONTROL: s_nxt.rdata = {6'h00, s_r.fatal_en, s_r.enable};
            MCS_OFS_MODE_SOURCE: s_nxt.rdata = {2'h0, s_r.mode, 2'h0, s_r.region};
            MCS_OFS_RESULT_STATE: s_nxt.rdata = {6'h00, s_r.ok && !s_r.busy, s_r.busy};
            default: s_nxt.rdata = 8'h00;
         endcase
      end
      if (i_dbg_access) begin
         s_nxt.held = 1'b1;
      end
      if (i_dbg_release && s_r.held) begin
         s_nxt.held = 1'b0;
         if (s_r.busy) begin
            start = 1'b1;
         end
      end
      if (wr_ctl) begin
         if (i_wdata[MCS_BIT_LOCAL_RESET] && (!s_r.fatal_en || !s_r.busy)) begin
            s_nxt.local_rst = 1'b1;
         end
         if (i_wdata[MCS_BIT_FATAL_EN] && !s_r.busy) begin
            s_nxt.fatal_en = 1'b1;
         end
         if (i_wdata[MCS_BIT_ENABLE]) begin
            s_nxt.enable = 1'b1;
            s_nxt.ok = 1'b0;
            s_nxt.busy = 1'b1;
            s_nxt.disable_pend = 1'b0;
            start = 1'b1;
         end else if (s_r.busy) begin
            s_nxt.disable_pend = 1'b1;
         end else begin
            s_nxt.enable = 1'b0;
         end
      end
      if (wr_ms && !s_r.busy) begin
         s_nxt.mode = i_wdata[MCS_POS_MODE +: 2];
         s_nxt.region = i_wdata[MCS_POS_REGION +: 2];
      end
      if (wr_st) begin
         if (!i_wdata[MCS_BIT_BUSY]) begin
            s_nxt.busy = 1'b0;
            s_nxt.st = MCS_IDLE;
            s_nxt.stall = 1'b0;
            start = 1'b0;
         end else if (!s_r.busy) begin
            s_nxt.busy = 1'b1;
            start = 1'b1;
         end
         if (i_wdata[MCS_BIT_OK]) begin
            s_nxt.ok = 1'b1;
         end else begin
            s_nxt.ok = 1'b0;
            if (s_r.fatal_en) begin
               s_nxt.nmi = 1'b1;
            end
         end
      end
      if (i_startup_req && !s_r.busy) begin
         s_nxt.enable = 1'b1;
         s_nxt.mode = MCS_MODE_STARTUP;
         s_nxt.region = i_startup_region;
         s_nxt.busy = 1'b1;
         s_nxt.ok = 1'b0;
         s_nxt.startup = 1'b1;
         start = 1'b1;
      end
      if (start) begin
         s_nxt.st = MCS_DELAY;
         s_nxt.cnt = MCS_START_DELAY - 2'h2;
         s_nxt.stall = 1'b0;
         s_nxt.crc = MCS_CRC_INIT;
         s_nxt.addr = 17'h00000;
         s_nxt.limit = region_limit(i_startup_req ? i_startup_region : s_r.region,
                                    i_last_memory_byte, i_boot_region_end, i_boot_app_region_end);
      end else if (!s_r.held && !i_sleep) begin
         unique case (s_r.st)
            MCS_IDLE: begin
               s_nxt.stall = 1'b0;
            end
            MCS_DELAY: begin
               if (s_r.cnt == 2'h0) begin
                  s_nxt.st = MCS_FETCH;
               end else begin
                  s_nxt.cnt = s_r.cnt - 2'h1;
               end
            end
            MCS_FETCH: begin
               s_nxt.stall = 1'b1;
               s_nxt.mem_rd = 1'b1;
               s_nxt.st = MCS_WAIT;
               s_nxt.cnt = MCS_FETCH_PERIOD - 2'h1;
            end
            MCS_WAIT: begin
               if (s_r.cnt == MCS_FETCH_PERIOD - 2'h2) begin
                  s_nxt.crc = crc_byte(crc_byte(s_r.crc, i_mem_rdata[7:0]), i_mem_rdata[15:8]);
                  s_nxt.addr = s_r.addr + 17'h00002;
               end
               if (s_r.cnt == 2'h1) begin
                  s_nxt.st = (s_nxt.addr >= s_r.limit) ? MCS_CHECK : MCS_FETCH;
               end
               s_nxt.cnt = s_r.cnt - 2'h1;
            end
            MCS_CHECK: begin
               s_nxt.st = MCS_IDLE;
               s_nxt.busy = 1'b0;
               s_nxt.stall = 1'b0;
               s_nxt.startup = 1'b0;
               if (s_r.disable_pend) begin
                  s_nxt.enable = 1'b0;
                  s_nxt.disable_pend = 1'b0;
               end
               if (s_r.crc == MCS_CRC_PASS) begin
                  s_nxt.ok = 1'b1;
               end else begin
                  s_nxt.ok = 1'b0;
                  if (s_r.fatal_en) begin
                     s_nxt.nmi = 1'b1;
                  end
                  if (s_r.startup) begin
                     s_nxt.fail = 1'b1;
                  end
               end
            end
            default: s_nxt.st = MCS_IDLE;
         endcase
      end
      // busy held
      // Busy is only lowered by completion, a debugger write or a local reset, never by holding.
      // clear one cycle later
      if (s_r.local_rst) begin
         s_nxt.local_rst = 1'b0;
         s_nxt.enable = 1'b0;
         s_nxt.mode = MCS_MODE_PRIORITY;
         s_nxt.region = MCS_REGION_WHOLE;
         s_nxt.busy = 1'b0;
         s_nxt.ok = 1'b1;
         s_nxt.st = MCS_IDLE;
         s_nxt.stall = 1'b0;
         s_nxt.disable_pend = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Holds all state; ok reads 1 out of system reset.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_r <= '0;
         s_r.st <= MCS_IDLE;
         s_r.ok <= 1'b1;
         s_r.crc <= MCS_CRC_INIT;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Outputs other than the constant vector come straight from the state register.
   assign o_rdata = s_r.rdata;
   assign o_mem_rd = s_r.mem_rd;
   assign o_mem_addr = s_r.addr[15:0];
   assign o_cpu_stall = s_r.stall;
   assign o_startup_fail = s_r.fail;
   assign o_nmi_req = s_r.nmi;
   assign o_nmi_vector = MCS_NMI_VECTOR;

endmodule : mcs_scanner

// >>> verification/mcs_mem_model.sv
// Purpose: Program memory as the scanner sees it.
// Assumes: 768 bytes, regions end at bytes 255, 511 and 767.
// Notes: Idle cycles show inverted data.
`timescale 1ns/100ps
module mcs_mem_model (
   input wire logic i_clk,
   input wire logic i_rd,
   input wire logic [15:0] i_addr,
   input wire logic i_bad,
   output logic [15:0] o_data
);
   logic [7:0] mem [0:767]; // Byte image.
   logic [15:0] c; // Running checksum from byte 0.
   // Fill a pattern and seal every region with its checksum.
   initial begin
      o_data = 16'h0000;
      c = 16'hffff;
      for (int i = 0; i < 768; i++) begin
         mem[i] = 8'(i * 7 + 3);
      end
      for (int i = 0; i < 768; i++) begin
         if (i % 256 == 254) begin
            mem[i] = c[15:8];
            mem[i + 1] = c[7:0];
         end
         for (int b = 7; b >= 0; b--) begin
            c = {c[14:0], 1'b0} ^ ((c[15] ^ mem[i][b]) ? 16'h1021 : 16'h0000);
         end
      end
   end
   // Word one cycle after the fetch; a flipped bit when told to corrupt.
   always @(posedge i_clk) begin
      if (i_rd) begin
         o_data <= {mem[i_addr[9:0] + 10'h1], mem[i_addr[9:0]]} ^ {15'h0, i_bad && i_addr == 16'h0};
      end else begin
         o_data <= ~o_data;
      end
   end
endmodule : mcs_mem_model

// >>> verification/mcs_chk_properties.sv
// Purpose: Timing checks at the scanner ports.
// Assumes: One clock domain.
// Notes: Bound to every scanner.
`timescale 1ns/100ps
module mcs_chk (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [1:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_dbg_access,
   input wire logic i_dbg_release,
   input wire logic i_sleep,
   input wire logic o_mem_rd,
   input wire logic [15:0] o_mem_addr,
   input wire logic o_cpu_stall,
   input wire logic o_nmi_req,
   input wire logic [7:0] o_nmi_vector
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   logic en_w; // Enable write from idle.
   assign en_w = i_wr && i_addr == 2'h0 && i_wdata[0] && !i_wdata[7] && !o_cpu_stall && !o_nmi_req;
   property p_start; en_w ##1 (!i_wr && !i_sleep && !i_dbg_access)[*3] |=> o_mem_rd && o_mem_addr == 16'h0; endproperty
   a_start: assert property (p_start) else $error("scan start late");
   property p_run; en_w |=> !o_cpu_stall [*3]; endproperty
   a_run: assert property (p_run) else $error("stall in delay");
   property p_gap; o_mem_rd |=> !o_mem_rd [*2]; endproperty
   a_gap: assert property (p_gap) else $error("fetch too soon");
   property p_step; o_mem_rd ##3 o_mem_rd |-> o_mem_addr == $past(o_mem_addr, 3) + 16'h2; endproperty
   a_step: assert property (p_step) else $error("fetch address step");
   property p_own; o_mem_rd |-> o_cpu_stall; endproperty
   a_own: assert property (p_own) else $error("fetch without stall");
   property p_sleep; i_sleep ##1 i_sleep |-> !o_mem_rd; endproperty
   a_sleep: assert property (p_sleep) else $error("fetch in sleep");
   property p_dbg; i_dbg_access && !i_dbg_release ##1 !i_dbg_release |=> !o_mem_rd; endproperty
   a_dbg: assert property (p_dbg) else $error("fetch while held");
   property p_nmi; o_nmi_req |=> o_nmi_req && o_nmi_vector == 8'h00; endproperty
   a_nmi: assert property (p_nmi) else $error("fatal request dropped");
endmodule : mcs_chk
bind mcs_scanner mcs_chk i_mcs_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_dbg_access(i_dbg_access), .i_dbg_release(i_dbg_release), .i_sleep(i_sleep),
   .o_mem_rd(o_mem_rd), .o_mem_addr(o_mem_addr), .o_cpu_stall(o_cpu_stall), .o_nmi_req(o_nmi_req),
   .o_nmi_vector(o_nmi_vector));

// >>> verification/testbench.sv
// Purpose: Self-checking bench for the scanner.
// Assumes: Regions of 256, 512 and 768 bytes.
// Notes: Offsets 0 control, 1 mode/source, 2 status.
`timescale 1ns/100ps
module testbench;
   // Row: region, corruption, last fetch address, final status.
   typedef struct {logic [1:0] src; logic bad; logic [15:0] last; logic [7:0] st;} mcs_row_type;
   mcs_row_type rows [4] = '{'{2'h0, 1'b0, 16'h02fe, 8'h02}, '{2'h1, 1'b0, 16'h01fe, 8'h02},
      '{2'h2, 1'b0, 16'h00fe, 8'h02}, '{2'h2, 1'b1, 16'h00fe, 8'h00}};
   logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, dbg = 1'b0, rel = 1'b0, dsw = 1'b0;
   logic slp = 1'b0, sreq = 1'b0, bad = 1'b0, mem_rd, nmi, sfail, stall;
   logic [1:0] addr = 2'h0, sreg = 2'h2;
   logic [7:0] wdata = 8'h00, rdata, vec;
   logic [15:0] mem_addr, mem_data, last_addr = 16'h0;
   int fail_count = 0, samples_checked = 0, fetches = 0, zeros = 0, cycles = 0, f0, f1;
   always #10 clk = ~clk;
   mcs_scanner i_mcs_scanner (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
      .i_rd(rd), .i_dbg_access(dbg), .i_dbg_release(rel), .i_dbg_status_wr(dsw), .i_sleep(slp),
      .i_startup_req(sreq), .i_startup_region(sreg), .i_last_memory_byte(16'h02ff),
      .i_boot_region_end(16'h0001), .i_boot_app_region_end(16'h0002), .i_mem_rdata(mem_data),
      .o_rdata(rdata), .o_mem_rd(mem_rd), .o_mem_addr(mem_addr), .o_cpu_stall(stall),
      .o_startup_fail(sfail), .o_nmi_req(nmi), .o_nmi_vector(vec));
   mcs_mem_model i_mcs_mem_model (.i_clk(clk), .i_rd(mem_rd), .i_addr(mem_addr), .i_bad(bad), .o_data(mem_data));
   // Count fetches and cut a hang short.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (mem_rd === 1'b1) begin
         fetches <= fetches + 1;
         zeros <= zeros + int'(mem_addr == 16'h0);
         last_addr <= mem_addr;
      end
      if (cycles == 40000) begin
         fail_count++;
         results();
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic wr_reg(input logic [1:0] a, input logic [7:0] d, input logic from_dbg = 1'b0);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      dsw <= from_dbg;
      @(posedge clk);
      wr <= 1'b0;
      dsw <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [1:0] a, output logic [7:0] v);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      v = rdata;
   endtask : rd_reg
   task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
      logic [7:0] v;
      rd_reg(a, v);
      check({8'h00, v}, {8'h00, exp});
   endtask : rd_chk
   // Poll status until busy clears.
   task automatic wait_idle;
      logic [7:0] v;
      v = 8'h01;
      for (int n = 0; n < 600 && v[0] !== 1'b0; n++) begin
         rd_reg(2'h2, v);
      end
   endtask : wait_idle
   // One-cycle pulse on startup, release and access.
   task automatic pulse(input logic [2:0] m);
      @(posedge clk);
      {sreq, rel, dbg} <= m;
      @(posedge clk);
      {sreq, rel, dbg} <= 3'b000;
   endtask : pulse
   task automatic results;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : results
   initial begin
      tick(3);
      rst_n <= 1'b1;
      rd_chk(2'h0, 8'h00);
      rd_chk(2'h2, 8'h02);
      rd_chk(2'h3, 8'h00);
      foreach (rows[i]) begin
         bad <= rows[i].bad;
         wr_reg(2'h1, {6'h00, rows[i].src});
         wr_reg(2'h0, 8'h01, i == 1);
         rd_chk(2'h2, 8'h01);
         wait_idle();
         rd_chk(2'h2, rows[i].st);
         check(last_addr, rows[i].last);
      end
      check({15'h0, nmi}, 16'h0);
      bad <= 1'b0;
      // Locked fields while busy, restart on rewrite.
      wr_reg(2'h0, 8'h01);
      wr_reg(2'h1, 8'h01);
      wr_reg(2'h0, 8'h03);
      wait_idle();
      rd_chk(2'h1, 8'h02);
      rd_chk(2'h0, 8'h01);
      f0 = fetches;
      wr_reg(2'h0, 8'h01);
      wr_reg(2'h0, 8'h00);
      wait_idle();
      check(16'(fetches - f0), 16'd128);
      rd_chk(2'h0, 8'h00);
      // Debugger hold mid-check, then restart.
      wr_reg(2'h0, 8'h01);
      tick(60);
      pulse(3'b001);
      tick(3);
      f1 = fetches;
      tick(20);
      check(16'(fetches - f1), 16'h0);
      rd_chk(2'h2, 8'h01);
      f1 = zeros;
      pulse(3'b010);
      wait_idle();
      check(16'(zeros - f1), 16'h1);
      // Debugger abandons a check, then queues one.
      wr_reg(2'h0, 8'h01);
      tick(40);
      pulse(3'b001);
      wr_reg(2'h2, 8'h02, 1'b1);
      pulse(3'b010);
      tick(3);
      f1 = fetches;
      tick(30);
      check(16'(fetches - f1), 16'h0);
      rd_chk(2'h2, 8'h02);
      f0 = fetches;
      pulse(3'b001);
      wr_reg(2'h2, 8'h01, 1'b1);
      tick(10);
      check(16'(fetches - f0), 16'h0);
      pulse(3'b010);
      wait_idle();
      check(16'(fetches - f0), 16'd128);
      // Sleep in the start delay, then mid-scan.
      f0 = fetches;
      wr_reg(2'h0, 8'h01);
      slp <= 1'b1;
      tick(10);
      check(16'(fetches - f0), 16'h0);
      slp <= 1'b0;
      tick(60);
      slp <= 1'b1;
      tick(3);
      f1 = fetches;
      tick(20);
      check(16'(fetches - f1), 16'h0);
      slp <= 1'b0;
      wait_idle();
      check(16'(fetches - f0), 16'd128);
      // Startup check: settings shown, failure sticks.
      pulse(3'b100);
      wait_idle();
      rd_chk(2'h0, 8'h01);
      rd_chk(2'h1, 8'h12);
      bad <= 1'b1;
      pulse(3'b100);
      wait_idle();
      check({15'h0, sfail}, 16'h1);
      // Local reset, sticky interrupt enable, fatal request and lock.
      wr_reg(2'h0, 8'h80);
      rd_chk(2'h1, 8'h00);
      rd_chk(2'h2, 8'h02);
      wr_reg(2'h0, 8'h02);
      wr_reg(2'h0, 8'h80);
      rd_chk(2'h0, 8'h02);
      wr_reg(2'h1, 8'h02);
      wr_reg(2'h0, 8'h03);
      wait_idle();
      check({15'h0, nmi}, 16'h1);
      rd_chk(2'h2, 8'h00);
      wr_reg(2'h1, 8'h00);
      rd_chk(2'h1, 8'h02);
      results();
   end
endmodule : testbench
